// File: hw/vtc_pkg.sv
package vtc_pkg;
	localparam int VA_W       = 32;
	localparam int PAGE_W     = 16;
	localparam int ROW_W      = 7;
	localparam int HPAGE_W    = PAGE_W - ROW_W;
	localparam int SETS       = 4;
	localparam int LINE_W     = 12;
	localparam int LIDX_W     = LINE_W + 1;
	localparam int RA_W       = PAGE_W + LINE_W + 2;
	localparam int PID_W      = 8;
	localparam int ADDR_W     = 8;

	localparam logic [ADDR_W-1:0] REG_CTRL    = 8'h00;
	localparam logic [ADDR_W-1:0] REG_TB_TAG  = 8'h04;
	localparam logic [ADDR_W-1:0] REG_TB_DATA = 8'h08;
	localparam logic [ADDR_W-1:0] REG_TB_CMD  = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_STATUS  = 8'h10;
	localparam logic [ADDR_W-1:0] REG_FAULT_VA = 8'h14;

	localparam int CTRL_KERNEL_BIT  = 8;
	localparam int CTRL_MISS_BIT    = 9;
	localparam int CTRL_ROM_BIT     = 10;
	localparam int CTRL_PARITY_BIT  = 11;
	localparam int TAG_HPAGE_LSB    = 8;
	localparam int TAG_WR_BIT       = 17;
	localparam int TAG_INV_BIT      = 18;
	localparam int CMD_SET_LSB      = 8;
	localparam int STAT_TBF_BIT     = 0;
	localparam int STAT_WP_BIT      = 1;
	localparam int STAT_BUSY_BIT    = 2;

	localparam logic RST_ROM_SEL    = 1'b1;
	localparam logic RST_FORCE_MISS = 1'b1;
	localparam logic RST_PARITY_EN  = 1'b0;
	localparam logic RST_KERNEL     = 1'b1;

	typedef struct packed {
		logic            valid;
		logic            store;
		logic            instr;
		logic [VA_W-1:0] va;
	} vtc_req_t;

	typedef struct packed {
		logic               invalid;
		logic               writable;
		logic [PID_W-1:0]   pid;
		logic [HPAGE_W-1:0] hpage;
		logic [PAGE_W-1:0]  xlat;
	} vtc_tb_entry_t;

	typedef struct packed {
		logic              invalid;
		logic              dirty;
		logic [PAGE_W-1:0] rpage;
	} vtc_ctag_t;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_WBACK  = 2'b01,
		ST_RELOAD = 2'b10
	} vtc_state_t;
endpackage

// File: hw/vtc_lookup.sv
// Function
// - Low 16 bits offset, high 16 page
// - Row index is page XOR pid, 7 bits
// - Four entries; match pid, high page, valid
// - Store to unwritable page raises interrupt
// - No matching entry raises translation fault
// - One buffer serves instructions and data
// - Line index is reference bit plus 12 bits
// - Hit needs tag equal page and valid
// - Miss reloads line, dirty victim written first
// - Word bits pick word, byte bits ignored
// - Kernel mode: identity map, no faults, writable
// - Real word address is page, line, word
// - One load per cycle; stores every two
// - Address in phase 1, data by phase 4
// - Hit or miss reported in next cycle
// - Store write enable on miss waits for reload
// - Cold reset: rom and miss set, parity off
// - Force miss makes every access without fault or write protect a clean miss
// - Force miss makes stores have no effect
// - Rom select bit drives its own pin
// - Warm start clears rom and miss bits
`timescale 1ns/1ns
module vtc_lookup
	import vtc_pkg::*;
#(
	parameter int TB_ROWS = 128,
	parameter int LINES   = 8192
)(
	input  wire logic              i_ref_clk,
	input  wire logic              i_rst_n,
	input  wire logic              i_ce,
	input  wire logic              i_warm_start,
	input  wire vtc_req_t          i_req,
	input  wire logic              i_mem_ack,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [31:0]       i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic [31:0]            o_rdata,
	output logic                   o_writeback_stage_load_hold,
	output logic                   o_tb_fault,
	output logic                   o_wprot_int,
	output logic                   o_ram_we,
	output logic [LIDX_W+1:0]      o_ram_addr,
	output logic [RA_W-1:0]        o_real_addr,
	output logic                   o_mem_req,
	output logic                   o_mem_write,
	output logic [RA_W-1:0]        o_mem_addr,
	output logic                   o_rom_boot_select,
	output logic                   o_parity_check_enable
);
	vtc_tb_entry_t     tb_mem [TB_ROWS][SETS];
	vtc_ctag_t         ctag_mem [LINES];
	vtc_state_t        st_q;
	vtc_req_t          wb_q;
	vtc_ctag_t         victim_q;
	logic [PID_W-1:0]  pid_q;
	logic              kernel_q;
	logic              miss_q;
	logic              boot_q;
	logic              tbf_sticky_q;
	logic              wp_sticky_q;
	logic [VA_W-1:0]   fault_va_q;
	logic [31:0]       tag_reg_q;
	logic [PAGE_W-1:0] data_reg_q;
	logic [PAGE_W-1:0] rpage_q;
	logic              reload_done;

	logic [PAGE_W-1:0]  vpn;
	logic [ROW_W-1:0]   row;
	logic [SETS-1:0]    match;
	logic               tb_ok;
	logic               tb_wr;
	logic [PAGE_W-1:0]  tb_xlat;
	logic [PAGE_W-1:0]  rpage;
	logic [LIDX_W-1:0]  lidx;
	vtc_ctag_t          ctag;
	logic               fault;
	logic               wprot;
	logic               chit;
	logic               acc;

	function automatic logic [PAGE_W-1:0] pick_xlat(input logic [SETS-1:0] m,
		input vtc_tb_entry_t e0, input vtc_tb_entry_t e1,
		input vtc_tb_entry_t e2, input vtc_tb_entry_t e3);
		logic [PAGE_W-1:0] r;
		r = ({PAGE_W{m[0]}} & e0.xlat) | ({PAGE_W{m[1]}} & e1.xlat)
			| ({PAGE_W{m[2]}} & e2.xlat) | ({PAGE_W{m[3]}} & e3.xlat);
		return r;
	endfunction

	// Lookup shared by instruction and data references
	always_comb
	begin
		vpn = i_req.va[VA_W-1:PAGE_W];
		row = vpn[ROW_W-1:0] ^ pid_q[ROW_W-1:0];
		tb_wr = 1'b0;
		for (int s = 0; s < SETS; s++)
		begin
			match[s] = !tb_mem[row][s].invalid && tb_mem[row][s].pid == pid_q
				&& tb_mem[row][s].hpage == vpn[PAGE_W-1:ROW_W];
			tb_wr = tb_wr | (match[s] & tb_mem[row][s].writable);
		end
		tb_ok = |match;
		tb_xlat = pick_xlat(match, tb_mem[row][0], tb_mem[row][1],
			tb_mem[row][2], tb_mem[row][3]);
		rpage = kernel_q ? vpn : tb_xlat;
		fault = !kernel_q && !tb_ok;
		wprot = !kernel_q && tb_ok && i_req.store && !tb_wr;
		lidx = {i_req.instr, i_req.va[PAGE_W-1:4]};
		ctag = ctag_mem[lidx];
		chit = !ctag.invalid && ctag.rpage == rpage && !miss_q;
		acc = i_ce && i_req.valid && st_q == ST_IDLE && !o_writeback_stage_load_hold;
		reload_done = i_ce && st_q == ST_RELOAD && i_mem_ack;
	end

	// Request stage; results seen in the following cycle
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wb_q <= '0;
			rpage_q <= '0;
			victim_q <= '0;
			o_ram_addr <= '0;
			o_real_addr <= '0;
			o_tb_fault <= 1'b0;
			o_wprot_int <= 1'b0;
		end
		else if (i_ce)
		begin
			o_tb_fault <= acc && fault;
			o_wprot_int <= acc && wprot;
			if (acc)
			begin
				wb_q <= i_req;
				rpage_q <= rpage;
				victim_q <= ctag;
				o_ram_addr <= {lidx, i_req.va[3:2]};
				o_real_addr <= {rpage, i_req.va[PAGE_W-1:2]};
			end
		end
	end

	// Hold, write enable and refill sequencing
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			st_q <= ST_IDLE;
			o_writeback_stage_load_hold <= 1'b0;
			o_ram_we <= 1'b0;
			o_mem_req <= 1'b0;
			o_mem_write <= 1'b0;
			o_mem_addr <= '0;
		end
		else if (i_ce)
		begin
			o_ram_we <= 1'b0;
			case (st_q)
				ST_IDLE:
				begin
					if (acc)
					begin
						o_writeback_stage_load_hold <= !fault && !wprot && !chit;
						// Write held back on miss until reload done
						o_ram_we <= i_req.store && chit && !fault && !wprot;
						if (!fault && !wprot && !chit)
						begin
							o_mem_req <= 1'b1;
							if (!ctag.invalid && ctag.dirty && !miss_q)
							begin
								st_q <= ST_WBACK;
								o_mem_write <= 1'b1;
								o_mem_addr <= {ctag.rpage, i_req.va[PAGE_W-1:4], 2'b00};
							end
							else
							begin
								st_q <= ST_RELOAD;
								o_mem_addr <= {rpage, i_req.va[PAGE_W-1:4], 2'b00};
							end
						end
					end
				end
				ST_WBACK:
				begin
					if (i_mem_ack)
					begin
						st_q <= ST_RELOAD;
						o_mem_write <= 1'b0;
						o_mem_addr <= {rpage_q, wb_q.va[PAGE_W-1:4], 2'b00};
					end
				end
				ST_RELOAD:
				begin
					if (i_mem_ack)
					begin
						st_q <= ST_IDLE;
						o_mem_req <= 1'b0;
						o_writeback_stage_load_hold <= 1'b0;
						o_ram_we <= wb_q.store && !miss_q;
					end
				end
				default:
				begin
					st_q <= ST_IDLE;
					o_mem_req <= 1'b0;
					o_mem_write <= 1'b0;
				end
			endcase
		end
	end

	// Cache tag store, no reset: contents random until reloaded
	always_ff @(posedge i_ref_clk)
	begin
		if (reload_done)
			ctag_mem[{wb_q.instr, wb_q.va[PAGE_W-1:4]}] <=
				'{invalid: 1'b0, dirty: wb_q.store && !miss_q, rpage: rpage_q};
		else if (acc && i_req.store && chit && !fault && !wprot)
			ctag_mem[lidx].dirty <= 1'b1;
	end

	// Translation buffer writes, every selected set at once
	always_ff @(posedge i_ref_clk)
	begin
		if (i_ce && i_wr && i_addr == REG_TB_CMD)
		begin
			for (int s = 0; s < SETS; s++)
			begin
				if (i_wdata[CMD_SET_LSB+s])
				begin
					tb_mem[i_wdata[ROW_W-1:0]][s] <= '{
						invalid:  tag_reg_q[TAG_INV_BIT],
						writable: tag_reg_q[TAG_WR_BIT],
						pid:      tag_reg_q[PID_W-1:0],
						hpage:    tag_reg_q[TAG_HPAGE_LSB+:HPAGE_W],
						xlat:     data_reg_q};
				end
			end
		end
	end

	// Control bits, boot values and warm start capture
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			boot_q <= 1'b1;
			kernel_q <= RST_KERNEL;
			miss_q <= RST_FORCE_MISS;
			o_rom_boot_select <= RST_ROM_SEL;
			o_parity_check_enable <= RST_PARITY_EN;
			pid_q <= '0;
			tag_reg_q <= '0;
			data_reg_q <= '0;
		end
		else if (i_ce)
		begin
			if (boot_q)
			begin
				boot_q <= 1'b0;
				miss_q <= !i_warm_start;
				o_rom_boot_select <= !i_warm_start;
			end
			else if (i_wr && i_addr == REG_CTRL)
			begin
				pid_q <= i_wdata[PID_W-1:0];
				kernel_q <= i_wdata[CTRL_KERNEL_BIT];
				miss_q <= i_wdata[CTRL_MISS_BIT];
				o_rom_boot_select <= i_wdata[CTRL_ROM_BIT];
				o_parity_check_enable <= i_wdata[CTRL_PARITY_BIT];
			end
			if (i_wr && i_addr == REG_TB_TAG)
				tag_reg_q <= i_wdata;
			if (i_wr && i_addr == REG_TB_DATA)
				data_reg_q <= i_wdata[PAGE_W-1:0];
		end
	end

	// Sticky fault flags, write one to clear, new event wins
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			tbf_sticky_q <= 1'b0;
			wp_sticky_q <= 1'b0;
			fault_va_q <= '0;
		end
		else if (i_ce)
		begin
			tbf_sticky_q <= (acc && fault) || (tbf_sticky_q
				&& !(i_wr && i_addr == REG_STATUS && i_wdata[STAT_TBF_BIT]));
			wp_sticky_q <= (acc && wprot) || (wp_sticky_q
				&& !(i_wr && i_addr == REG_STATUS && i_wdata[STAT_WP_BIT]));
			if (acc && (fault || wprot))
				fault_va_q <= i_req.va;
		end
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_rdata <= '0;
		else if (i_ce)
		begin
			o_rdata <= '0;
			if (i_rd)
			begin
				case (i_addr)
					REG_CTRL:
						o_rdata <= {20'h0, o_parity_check_enable, o_rom_boot_select,
							miss_q, kernel_q, pid_q};
					REG_TB_TAG:   o_rdata <= tag_reg_q;
					REG_TB_DATA:  o_rdata <= {16'h0, data_reg_q};
					REG_STATUS:
						o_rdata <= {29'h0, st_q != ST_IDLE, wp_sticky_q, tbf_sticky_q};
					REG_FAULT_VA: o_rdata <= fault_va_q;
					default:      o_rdata <= '0;
				endcase
			end
		end
	end

	// CPU keeps a store address for two cycles; one request per free cycle
	logic              acc_q;
	logic              kern_acc_q;
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			acc_q <= 1'b0;
			kern_acc_q <= 1'b0;
		end
		else if (i_ce)
		begin
			acc_q <= acc;
			kern_acc_q <= kernel_q;
		end
	end

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	property p_kernel_no_fault;
		acc_q && kern_acc_q |-> !o_tb_fault;
	endproperty
	a_kernel_no_fault: assert property (p_kernel_no_fault)
		else $error("fault raised in kernel mode");

	property p_tb_fault;
		acc && !kernel_q && !tb_ok |=> o_tb_fault && !o_writeback_stage_load_hold;
	endproperty
	a_tb_fault: assert property (p_tb_fault)
		else $error("missing translation fault");

	property p_wprot;
		i_ce && acc && wprot |=> o_wprot_int && !o_ram_we;
	endproperty
	a_wprot: assert property (p_wprot)
		else $error("write protect not raised");

	property p_force_miss;
		i_ce && acc && miss_q && !fault && !wprot |=> o_writeback_stage_load_hold && o_mem_req;
	endproperty
	a_force_miss: assert property (p_force_miss)
		else $error("forced miss not taken");

	property p_store_no_effect;
		i_ce && acc && i_req.store && miss_q |=> !o_ram_we && !o_mem_write;
	endproperty
	a_store_no_effect: assert property (p_store_no_effect)
		else $error("store affected cache in force miss");

	property p_hold_busy;
		st_q != ST_IDLE |-> o_writeback_stage_load_hold;
	endproperty
	a_hold_busy: assert property (p_hold_busy)
		else $error("hold dropped during refill");

	property p_addr;
		i_ce && acc |=> o_real_addr == {$past(rpage), $past(i_req.va[15:2])}
			&& o_ram_addr == {$past(i_req.instr), $past(i_req.va[15:2])};
	endproperty
	a_addr: assert property (p_addr)
		else $error("address formed wrongly");

	property p_warm;
		i_ce && boot_q && i_warm_start |=> !o_rom_boot_select && !miss_q;
	endproperty
	a_warm: assert property (p_warm)
		else $error("warm start bits not cleared");

	c_hit_load: cover property (acc && chit && !fault && !i_req.store);
	c_wback: cover property (st_q == ST_WBACK ##[1:20] st_q == ST_RELOAD);
	c_fault: cover property (o_tb_fault);
	c_store_hit: cover property (o_ram_we && !o_writeback_stage_load_hold);
endmodule // vtc_lookup

// File: tb/vtc_mem_model.sv
`timescale 1ns/1ns
module vtc_mem_model (
	input  wire logic       i_ref_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_mem_req,
	input  wire logic [3:0] i_dly,
	output logic            o_mem_ack
);
	logic [3:0] cnt_q;
	// One ack per transfer after i_dly idle cycles
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cnt_q     <= 4'h0;
			o_mem_ack <= 1'b0;
		end
		else if (o_mem_ack)
		begin
			cnt_q     <= 4'h0;
			o_mem_ack <= 1'b0;
		end
		else if (i_mem_req)
		begin
			if (cnt_q >= i_dly)
				o_mem_ack <= 1'b1;
			else
				cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule // vtc_mem_model

// File: tb/tb_top.sv
`timescale 1ns/1ns
module tb_top
	import vtc_pkg::*;
;
	logic              i_ref_clk = 1'b0;
	logic              i_rst_n;
	logic              i_ce;
	logic              i_warm_start;
	vtc_req_t          i_req;
	logic              i_mem_ack;
	logic [ADDR_W-1:0] i_addr;
	logic [31:0]       i_wdata;
	logic              i_wr;
	logic              i_rd;
	logic [31:0]       o_rdata;
	logic              o_hold;
	logic              o_tb_fault;
	logic              o_wprot_int;
	logic              o_ram_we;
	logic [LIDX_W+1:0] o_ram_addr;
	logic [RA_W-1:0]   o_real_addr;
	logic              o_mem_req;
	logic              o_mem_write;
	logic [RA_W-1:0]   o_mem_addr;
	logic              o_rom;
	logic              o_par;
	logic [3:0]        m_dly;
	logic              s_hold, s_flt, s_wp, s_we;
	int                errors = 0;
	int                n_tests = 0;
	int                cyc = 0;
	int                we_cnt = 0;
	int                w0;

	always #5 i_ref_clk = ~i_ref_clk;

	vtc_lookup uut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
		.i_warm_start(i_warm_start), .i_req(i_req), .i_mem_ack(i_mem_ack),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .o_writeback_stage_load_hold(o_hold),
		.o_tb_fault(o_tb_fault), .o_wprot_int(o_wprot_int), .o_ram_we(o_ram_we),
		.o_ram_addr(o_ram_addr), .o_real_addr(o_real_addr), .o_mem_req(o_mem_req),
		.o_mem_write(o_mem_write), .o_mem_addr(o_mem_addr),
		.o_rom_boot_select(o_rom), .o_parity_check_enable(o_par));

	vtc_mem_model mem (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
		.i_mem_req(o_mem_req), .i_dly(m_dly), .o_mem_ack(i_mem_ack));

	task automatic end_sim;
		if (errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	always @(posedge i_ref_clk)
	begin
		cyc++;
		if (o_ram_we === 1'b1)
			we_cnt++;
		if (cyc == 5000)
		begin
			errors++;
			end_sim();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		i_addr  <= a;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		@(posedge i_ref_clk);
		i_addr <= a;
		i_rd   <= 1'b1;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, exp);
	endtask

	// Stores stay on the bus two cycles
	task automatic req(input logic st, input logic ins, input logic [31:0] va);
		@(posedge i_ref_clk);
		i_req <= '{1'b1, st, ins, va};
		@(posedge i_ref_clk);
		if (!st)
			i_req.valid <= 1'b0;
		#1;
		s_hold = o_hold;
		s_flt  = o_tb_fault;
		s_wp   = o_wprot_int;
		s_we   = o_ram_we;
		if (st)
		begin
			@(posedge i_ref_clk);
			i_req.valid <= 1'b0;
		end
	endtask

	task automatic wait_idle;
		int n;
		n = 0;
		while (o_hold !== 1'b0 && n < 100)
		begin
			@(posedge i_ref_clk);
			#1;
			n++;
		end
		if (n == 100)
			errors++;
	endtask

	task automatic wait_ack;
		int n;
		n = 0;
		while (i_mem_ack !== 1'b1 && n < 100)
		begin
			@(posedge i_ref_clk);
			#1;
			n++;
		end
		if (n == 100)
			errors++;
		@(posedge i_ref_clk);
		#1;
	endtask

	task automatic do_reset(input logic warm);
		i_warm_start <= warm;
		i_rst_n      <= 1'b0;
		repeat (8) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		repeat (2) @(posedge i_ref_clk);
		#1;
	endtask

	initial
	begin
		i_rst_n = 1'b0;
		i_warm_start = 1'b0;
		i_req = '0;
		i_addr = '0;
		i_wdata = '0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		m_dly = 4'h0;
		i_ce = 1'b1;
		do_reset(1'b0);
		chk(o_rom, 1'b1);
		chk(o_par, 1'b0);
		rd(REG_CTRL, 32'h0000_0700);
		rd(8'hFC, 32'h0000_0000);
		req(1'b0, 1'b0, 32'h0003_5678);
		chk(s_hold, 1'b1);
		chk(o_mem_write, 1'b0);
		chk(o_mem_addr, {16'h0003, 12'h567, 2'h0});
		wait_idle();
		chk(o_mem_req, 1'b0);
		req(1'b0, 1'b0, 32'h0003_5678);
		chk(s_hold, 1'b1);
		wait_idle();
		req(1'b0, 1'b1, 32'h0003_5678);
		chk(s_hold, 1'b1);
		wait_idle();
		w0 = we_cnt;
		req(1'b1, 1'b0, 32'h0003_5678);
		chk(s_we, 1'b0);
		wait_idle();
		@(posedge i_ref_clk);
		#1;
		chk(we_cnt - w0, 0);
		wr(REG_CTRL, 32'h0000_0100);
		@(posedge i_ref_clk);
		#1;
		chk(o_rom, 1'b0);
		req(1'b0, 1'b0, 32'h0003_567B);
		chk(s_hold, 1'b0);
		chk(o_real_addr, {16'h0003, 14'h159E});
		chk(o_ram_addr, {1'b0, 14'h159E});
		req(1'b1, 1'b0, 32'h0003_5678);
		chk(s_we, 1'b1);
		chk(s_flt, 1'b0);
		wait_idle();
		req(1'b0, 1'b1, 32'h0003_5678);
		chk(o_ram_addr, {1'b1, 14'h159E});
		wait_idle();
		m_dly <= 4'h5;
		req(1'b0, 1'b0, 32'h0007_5678);
		chk(s_hold, 1'b1);
		chk(o_mem_write, 1'b1);
		chk(o_mem_addr, {16'h0003, 12'h567, 2'h0});
		wait_ack();
		chk(o_hold, 1'b1);
		chk(o_mem_write, 1'b0);
		chk(o_mem_addr, {16'h0007, 12'h567, 2'h0});
		wait_idle();
		wr(REG_TB_TAG, 32'h0000_0105);
		wr(REG_TB_DATA, 32'h0000_1234);
		wr(REG_TB_CMD, 32'h0000_0F20);
		wr(REG_CTRL, 32'h0000_0805);
		i_ce <= 1'b0;
		wr(REG_CTRL, 32'h0000_0100);
		i_ce <= 1'b1;
		req(1'b1, 1'b0, 32'h00A5_1230);
		chk(s_wp, 1'b1);
		chk(s_flt, 1'b0);
		chk(o_real_addr, {16'h1234, 14'h048C});
		chk(o_par, 1'b1);
		wait_idle();
		req(1'b0, 1'b1, 32'h00A5_5678);
		chk(s_flt, 1'b0);
		chk(s_hold, 1'b1);
		chk(o_real_addr, {16'h1234, 14'h159E});
		chk(o_mem_addr, {16'h1234, 12'h567, 2'h0});
		wait_idle();
		req(1'b0, 1'b0, 32'h01A5_1230);
		chk(s_flt, 1'b1);
		chk(s_hold, 1'b0);
		rd(REG_STATUS, 32'h0000_0003);
		rd(REG_FAULT_VA, 32'h01A5_1230);
		rd(REG_TB_TAG, 32'h0000_0105);
		wr(REG_STATUS, 32'h0000_0003);
		rd(REG_STATUS, 32'h0000_0000);
		do_reset(1'b1);
		chk(o_rom, 1'b0);
		rd(REG_CTRL, 32'h0000_0100);
		end_sim();
	end
endmodule // tb_top
